/* scmma_averager.sv */
`include "scmma_regs.svh"
module scmma_averager #(
	parameter int          CELLS      = 12,
	parameter int unsigned AVE_CYCLES = `SCMMA_AVE_CYCLES
) (
	input  wire logic                mclk,
	input  wire logic                reset,
	input  wire logic                adc_sample_en,
	input  wire logic                cell_valid,
	input  wire logic [3:0]          cell_index,
	input  wire logic [10:0]         cell_code,
	input  wire scmma_pkg::scmma_bus_t bus,
	output logic      [15:0]         rdata,
	output logic                     primary_active,
	output logic                     busy
);
	localparam int CW = $clog2(CELLS);

	scmma_pkg::scmma_state_t state, next_state;
	scmma_pkg::scmma_result_t max_res, next_max_res, min_res, next_min_res;
	logic [11:0] select, next_select, partition, next_partition;
	logic [15:0] meas_len, next_meas_len;
	logic [15:0] period_cnt, next_period_cnt;
	logic [5:0]  div_cnt, next_div_cnt;
	logic [31:0] ave_cnt, next_ave_cnt;
	logic [CW-1:0] scan, next_scan;
	logic        scanning, next_scanning;
	logic [10:0] smax, next_smax, smin, next_smin;
	logic [26:0] sum_max, next_sum_max, sum_min, next_sum_min;
	logic [15:0] nsamp, next_nsamp;
	logic [15:0] next_rdata;
	logic [10:0] mem_rdata;
	logic        scan_valid, next_scan_valid;
	logic [CW-1:0] scan_q, next_scan_q;
	logic        start_wr;

	// Division of an accumulated sum by its sample count
	function automatic logic [10:0] avg(input logic [26:0] s,
		input logic [15:0] n);
		logic [26:0] q;
		q = (n == 16'h0000) ? 27'h0 : s / {11'h0, n};
		avg = q[10:0];
	endfunction : avg

	scmma_cell_mem #(.CELLS(CELLS)) u_mem (
		.mclk  (mclk),
		.we    (cell_valid),
		.waddr (cell_index[CW-1:0]),
		.wdata (cell_code),
		.raddr (scan),
		.rdata (mem_rdata)
	);

	assign start_wr = bus.write && bus.addr == `SCMMA_OFF_CTRL &&
		bus.wdata[`SCMMA_CTRL_SECONDARY_BIT];
	assign busy = state != scmma_pkg::SCMMA_IDLE;

	always_comb begin
		next_state      = state;
		next_select     = select;
		next_partition  = partition;
		next_meas_len   = meas_len;
		next_period_cnt = period_cnt;
		next_div_cnt    = div_cnt;
		next_ave_cnt    = ave_cnt;
		next_scan       = scan;
		next_scanning   = scanning;
		next_scan_valid = 1'b0;
		next_scan_q     = scan;
		next_smax       = smax;
		next_smin       = smin;
		next_sum_max    = sum_max;
		next_sum_min    = sum_min;
		next_nsamp      = nsamp;
		next_max_res    = max_res;
		next_min_res    = min_res;
		if (bus.write) begin
			case (bus.addr)
				`SCMMA_OFF_SELECT:    next_select = bus.wdata[11:0];
				`SCMMA_OFF_PARTITION: next_partition = bus.wdata[11:0];
				`SCMMA_OFF_MEAS_LEN:  next_meas_len = bus.wdata;
				default: ;
			endcase
		end
		case (state)
			scmma_pkg::SCMMA_IDLE: begin
				if (start_wr) begin
					next_state      = scmma_pkg::SCMMA_MEASURE;
					next_period_cnt = 16'h0;
					next_div_cnt    = 6'h0;
					next_sum_max    = 27'h0;
					next_sum_min    = 27'h0;
					next_nsamp      = 16'h0;
				end
			end
			scmma_pkg::SCMMA_MEASURE: begin
				// Window is counted in ADC samples, same as the primary
				if (adc_sample_en) begin
					next_period_cnt = period_cnt + 16'h1;
					next_div_cnt = div_cnt + 6'h1;
					if (div_cnt == 6'(`SCMMA_SAMPLE_DIV - 1)) begin
						next_scanning = 1'b1;
						next_scan     = '0;
						next_smax     = 11'h000;
						next_smin     = 11'h7ff;
					end
				end
				if (adc_sample_en && period_cnt == meas_len - 16'h1) begin
					next_state   = scmma_pkg::SCMMA_AVERAGE;
					next_ave_cnt = 32'h0;
				end
			end
			scmma_pkg::SCMMA_AVERAGE: begin
				next_ave_cnt = ave_cnt + 32'h1;
				if (ave_cnt == AVE_CYCLES - 1) begin
					next_state = scmma_pkg::SCMMA_IDLE;
					next_max_res.code = avg(sum_max, nsamp);
					next_min_res.code = avg(sum_min, nsamp);
					next_max_res.count = max_res.count + 2'h1;
					next_min_res.count = min_res.count + 2'h1;
				end
			end
			default: next_state = scmma_pkg::SCMMA_IDLE;
		endcase
		// Closing sweep starts with the window end, so it runs on
		// into averaging; AVE_CYCLES must outlast one sweep
		if (state != scmma_pkg::SCMMA_IDLE) begin
			if (scanning) begin
				next_scan_valid = 1'b1;
				if (scan == CW'(CELLS - 1)) begin
					next_scanning = 1'b0;
				end else begin
					next_scan = scan + CW'(1);
				end
			end
			if (scan_valid && select[scan_q]) begin
				if (mem_rdata > smax) next_smax = mem_rdata;
				if (mem_rdata < smin) next_smin = mem_rdata;
			end
			// Last compare of the sweep folds into the sums
			if (scan_valid && scan_q == CW'(CELLS - 1) &&
				select != 12'h0) begin
				next_sum_max = sum_max + 27'(next_smax);
				next_sum_min = sum_min + 27'(next_smin);
				next_nsamp   = nsamp + 16'h1;
			end
		end
	end

	always_comb begin
		next_rdata = 16'h0;
		if (bus.read) begin
			case (bus.addr)
				`SCMMA_OFF_SELECT:    next_rdata = {4'h0, select};
				`SCMMA_OFF_PARTITION: next_rdata = {4'h0, partition};
				`SCMMA_OFF_MAXRES:    next_rdata = {2'h0, max_res.count,
					1'b0, max_res.code};
				`SCMMA_OFF_MINRES:    next_rdata = {2'h0, min_res.count,
					1'b0, min_res.code};
				`SCMMA_OFF_STATUS:    next_rdata = {14'h0, state};
				`SCMMA_OFF_MEAS_LEN:  next_rdata = meas_len;
				default:              next_rdata = 16'h0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state      <= scmma_pkg::SCMMA_IDLE;
			select     <= `SCMMA_RST_SELECT;
			partition  <= `SCMMA_RST_PARTITION;
			meas_len   <= `SCMMA_RST_MEAS_LEN;
			period_cnt <= 16'h0;
			div_cnt    <= 6'h0;
			ave_cnt    <= 32'h0;
			scan       <= '0;
			scanning   <= 1'b0;
			scan_valid <= 1'b0;
			scan_q     <= '0;
			smax       <= 11'h0;
			smin       <= 11'h7ff;
			sum_max    <= 27'h0;
			sum_min    <= 27'h0;
			nsamp      <= 16'h0;
			max_res    <= '0;
			min_res    <= '0;
			rdata      <= 16'h0;
		end else begin
			state      <= next_state;
			select     <= next_select;
			partition  <= next_partition;
			meas_len   <= next_meas_len;
			period_cnt <= next_period_cnt;
			div_cnt    <= next_div_cnt;
			ave_cnt    <= next_ave_cnt;
			scan       <= next_scan;
			scanning   <= next_scanning;
			scan_valid <= next_scan_valid;
			scan_q     <= next_scan_q;
			smax       <= next_smax;
			smin       <= next_smin;
			sum_max    <= next_sum_max;
			sum_min    <= next_sum_min;
			nsamp      <= next_nsamp;
			max_res    <= next_max_res;
			min_res    <= next_min_res;
			rdata      <= next_rdata;
		end
	end

	assign primary_active = state == scmma_pkg::SCMMA_MEASURE;

	property p_avg_len;
		@(posedge mclk) disable iff (reset)
		$rose(state == scmma_pkg::SCMMA_AVERAGE) |->
			(state == scmma_pkg::SCMMA_AVERAGE)[*8];
	endproperty
	a_avg_len: assert property (p_avg_len) else $error("average too short");

	property p_cnt_step;
		@(posedge mclk) disable iff (reset)
		$changed(max_res.count) && !$past(reset) |->
			max_res.count == $past(max_res.count) + 2'h1;
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("bad counter step");

	property p_hold;
		@(posedge mclk) disable iff (reset)
		state != scmma_pkg::SCMMA_AVERAGE |=> $stable(max_res);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed early");

	property p_start;
		@(posedge mclk) disable iff (reset)
		state == scmma_pkg::SCMMA_IDLE && start_wr |=>
			state == scmma_pkg::SCMMA_MEASURE;
	endproperty
	a_start: assert property (p_start) else $error("start ignored");

	property p_order;
		@(posedge mclk) disable iff (reset)
		state == scmma_pkg::SCMMA_MEASURE |-> smin <= smax || smin == 11'h7ff;
	endproperty
	a_order: assert property (p_order) else $error("min above max");

	property p_min_step;
		@(posedge mclk) disable iff (reset)
		$changed(min_res.count) && !$past(reset) |->
			min_res.count == $past(min_res.count) + 2'h1;
	endproperty
	a_min_step: assert property (p_min_step)
		else $error("min counter bad step");

	// Update is two steps: averaging ends, then both registers land
	sequence s_ave_done;
		state == scmma_pkg::SCMMA_AVERAGE && ave_cnt == AVE_CYCLES - 1;
	endsequence

	sequence s_both_updated;
		state == scmma_pkg::SCMMA_IDLE &&
			max_res.count == $past(max_res.count) + 2'h1 &&
			min_res.count == $past(min_res.count) + 2'h1;
	endsequence

	property p_update;
		@(posedge mclk) disable iff (reset)
		s_ave_done |=> s_both_updated;
	endproperty
	a_update: assert property (p_update)
		else $error("results not updated");

	sequence s_period_end;
		state == scmma_pkg::SCMMA_MEASURE && adc_sample_en &&
			div_cnt == 6'(`SCMMA_SAMPLE_DIV - 1);
	endsequence

	sequence s_sweep_open;
		scanning && scan == '0 && smax == 11'h000 && smin == 11'h7ff
			##1 scan_valid && scan_q == '0;
	endsequence

	property p_sample;
		@(posedge mclk) disable iff (reset)
		s_period_end |=> s_sweep_open;
	endproperty
	a_sample: assert property (p_sample)
		else $error("sample period without sweep");

	property p_excl;
		@(posedge mclk) disable iff (reset)
		scan_valid && !select[scan_q] |=> $stable(smax) && $stable(smin);
	endproperty
	a_excl: assert property (p_excl)
		else $error("unselected cell used");
endmodule : scmma_averager

/* scmma_cell_mem.sv */
// Small memory holding the latest 11-bit code of each cell
module scmma_cell_mem #(
	parameter int CELLS = 12
) (
	input  wire logic                     mclk,
	input  wire logic                     we,
	input  wire logic [$clog2(CELLS)-1:0] waddr,
	input  wire logic [10:0]              wdata,
	input  wire logic [$clog2(CELLS)-1:0] raddr,
	output logic      [10:0]              rdata
);
	logic [10:0] store [CELLS];

	always_ff @(posedge mclk) begin
		if (we) begin
			store[waddr] <= wdata;
		end
		rdata <= store[raddr];
	end
endmodule : scmma_cell_mem

/* scmma_pkg.sv */
package scmma_pkg;
	typedef enum logic [1:0] {
		SCMMA_IDLE,
		SCMMA_MEASURE,
		SCMMA_AVERAGE
	} scmma_state_t;

	typedef struct packed {
		logic [1:0]  count;
		logic [10:0] code;
	} scmma_result_t;

	typedef struct packed {
		logic        write;
		logic        read;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} scmma_bus_t;
endpackage : scmma_pkg

/* scmma_regs.svh */
`ifndef SCMMA_REGS_SVH
`define SCMMA_REGS_SVH

// Register offsets on the plain register port
`define SCMMA_OFF_CTRL      4'h0
`define SCMMA_OFF_SELECT    4'h1
`define SCMMA_OFF_PARTITION 4'h2
`define SCMMA_OFF_MAXRES    4'h3
`define SCMMA_OFF_MINRES    4'h4
`define SCMMA_OFF_STATUS    4'h5
`define SCMMA_OFF_MEAS_LEN  4'h6

// Control register fields
`define SCMMA_CTRL_PRIMARY_BIT   0
`define SCMMA_CTRL_SECONDARY_BIT 1

// Result register fields: code in [10:0], counter in [13:12]
`define SCMMA_RES_CODE_LSB 0
`define SCMMA_RES_CNT_LSB  12

// Reset values
`define SCMMA_RST_SELECT    12'h000
`define SCMMA_RST_PARTITION 12'h000
`define SCMMA_RST_MEAS_LEN  16'h0010

// Timing
`define SCMMA_SAMPLE_DIV    64
`define SCMMA_CLK_MHZ       200
`define SCMMA_AVE_MIN_US    286
`define SCMMA_AVE_TYP_US    298
`define SCMMA_AVE_MAX_US    311
`define SCMMA_AVE_CYCLES    (`SCMMA_AVE_TYP_US * `SCMMA_CLK_MHZ)

`endif

/* test_scmma_averager.sv */
module test_scmma_averager;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AVE = 20;
	logic                   mclk = 0;
	logic                   reset = 1;
	logic                   adc_sample_en = 0;
	logic                   cell_valid = 0;
	logic [3:0]             cell_index = '0;
	logic [10:0]            cell_code = '0;
	scmma_pkg::scmma_bus_t  bus = '0;
	logic [15:0]            rdata;
	logic                   primary_active;
	logic                   busy;
	logic [15:0]            exp_q[$];
	logic                   rd_pend = 0;
	logic [10:0]            codes[12];
	logic [15:0]            prev_max = '0;
	logic [15:0]            prev_min = '0;
	logic [11:0]            sels[4] = '{12'h5a3, 12'h010, 12'h801, 12'hfff};
	int                     seed = 32'h884cb413;
	int                     bad_count = 0;
	int                     checks_done = 0;

	scmma_averager #(.CELLS(12), .AVE_CYCLES(AVE)) scmma_averager_i (
		.mclk(mclk), .reset(reset), .adc_sample_en(adc_sample_en),
		.cell_valid(cell_valid), .cell_index(cell_index),
		.cell_code(cell_code), .bus(bus), .rdata(rdata),
		.primary_active(primary_active), .busy(busy));

	always #2.5 mclk = ~mclk;
	// Every other cycle, so a 64-sample period spans 128 clocks
	always @(posedge mclk) adc_sample_en <= ~adc_sample_en;

	task automatic ok(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : ok

	task automatic tally_and_finish;
		if (bad_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	// Read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_pend) ok(rdata, exp_q.pop_front());
		rd_pend <= bus.read;
	end

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus.write <= 1;
		bus.addr  <= a;
		bus.wdata <= d;
		@(posedge mclk);
		bus.write <= 0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge mclk);
		exp_q.push_back(e);
		bus.read <= 1;
		bus.addr <= a;
		@(posedge mclk);
		bus.read <= 0;
	endtask : rd

	// Plain mean of two samples, rounded down
	function automatic logic [10:0] mean2(input logic [10:0] a,
		input logic [10:0] b);
		logic [11:0] s;
		s = {1'b0, a} + {1'b0, b};
		mean2 = s[11:1];
	endfunction : mean2

	// Fresh random codes for all cells, extremes of the selected ones
	task automatic load(input logic [11:0] sel, output logic [10:0] mx,
		output logic [10:0] mn);
		mx = '0;
		mn = 11'h7ff;
		for (int i = 0; i < 12; i++) begin
			codes[i] = 11'($random(seed));
			@(posedge mclk);
			cell_valid <= 1;
			cell_index <= 4'(i);
			cell_code  <= codes[i];
			@(posedge mclk);
			cell_valid <= 0;
			if (sel[i] && codes[i] > mx) mx = codes[i];
			if (sel[i] && codes[i] < mn) mn = codes[i];
		end
	endtask : load

	task automatic run(input logic [11:0] sel, input logic [1:0] cnt);
		logic [10:0] mx;
		logic [10:0] mn;
		logic [10:0] mx2;
		logic [10:0] mn2;
		int          n;
		load(sel, mx, mn);
		wr(4'h1, {4'h0, sel});
		wr(4'h2, {4'h0, sel});
		wr(4'h6, 16'h0080);
		wr(4'h0, 16'h0002);
		@(negedge mclk);
		ok(16'(busy), 16'h0001);
		ok(16'(primary_active), 16'h0001);
		// A second start while busy must not add an update
		wr(4'h0, 16'h0002);
		rd(4'h3, prev_max);
		rd(4'h4, prev_min);
		rd(4'h2, {4'h0, sel});
		rd(4'h5, 16'(scmma_pkg::SCMMA_MEASURE));
		// Past the first sweep, well before the second one
		repeat (140) @(posedge mclk);
		load(sel, mx2, mn2);
		n = 0;
		while (primary_active !== 1'b0 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		ok(16'(busy), 16'h0001);
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		ok(16'(n), 16'(AVE));
		prev_max = {2'b00, cnt, 1'b0, mean2(mx, mx2)};
		prev_min = {2'b00, cnt, 1'b0, mean2(mn, mn2)};
		rd(4'h3, prev_max);
		rd(4'h4, prev_min);
		rd(4'h5, 16'h0000);
	endtask : run

	initial begin
		repeat (2) @(posedge mclk);
		reset <= 0;
		@(negedge mclk);
		ok(16'(busy), 16'h0000);
		rd(4'h1, 16'h0000);
		rd(4'h2, 16'h0000);
		rd(4'h6, 16'h0010);
		rd(4'h3, 16'h0000);
		rd(4'hf, 16'h0000);
		// Four runs so the update counter wraps back to zero
		for (int r = 0; r < 4; r++) run(sels[r], 2'(r + 1));
		repeat (3) @(posedge mclk);
		ok(16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		tally_and_finish();
	end
endmodule : test_scmma_averager
